// File: rtl/psl_pkg.sv
package psl_pkg;
    // Clocking: 200 MHz core clock, 10 MHz sample clock as enable pulse
    localparam int CLK_MHZ = 200;
    localparam int TICK_MHZ = 10;
    localparam int DIV_CYCLES = CLK_MHZ / TICK_MHZ;
    localparam int TICK_NS = 1000 / TICK_MHZ;
    localparam int DW_DIV = 5;

    // Fixed front-end delay ahead of the position counter feeding this block
    localparam int FRONT_NS = 51;
    // Delay-bit set: long data age, short sample delay
    localparam int AGE_LONG_NS = 2951;
    localparam int DLY_SHORT_NS = 100;
    // Delay-bit clear: short data age, long sample delay
    localparam int AGE_SHORT_NS = 251;
    localparam int DLY_LONG_NS = 2800;
    // Rear connector hardware position latency
    localparam int HW_NS = 3051;

    localparam int AGE_LONG_T = (AGE_LONG_NS - FRONT_NS) / TICK_NS;
    localparam int AGE_SHORT_T = (AGE_SHORT_NS - FRONT_NS) / TICK_NS;
    localparam int DLY_SHORT_T = DLY_SHORT_NS / TICK_NS;
    localparam int DLY_LONG_T = DLY_LONG_NS / TICK_NS;
    localparam int HW_T = (HW_NS - FRONT_NS) / TICK_NS;
    localparam int HIST_DEPTH = AGE_LONG_T;

    localparam int NREG = 8;
    localparam int NAXIS = 4;
    localparam int DW = 32;
    localparam int IW = 3;
    localparam int CW = 5;
    localparam int LW = 10;

    typedef logic [DW-1:0] psl_word_t;

    // Bus read start level and index of the register being read
    typedef struct packed {
        logic start;
        logic [IW-1:0] idx;
    } psl_rd_t;
endpackage

// File: rtl/psl_chan.sv
`timescale 1ns/1ps
module psl_chan import psl_pkg::*; (
    input wire logic clock, // Core clock
    input wire logic nrst, // Async reset, active low
    input wire logic tick, // 10 MHz edge enable
    input wire logic take, // Sample at this tick
    input wire logic fast, // Delay bit: 1 = short sample delay
    input wire psl_word_t val, // Live counter value
    output psl_word_t hw_tap, // Value at hardware output age
    output psl_word_t out_q, // Readable register
    output logic avail_q // Register holds the latest sample
);
    localparam int FAST_GAP = DIV_CYCLES * DLY_SHORT_T + 1;
    localparam int SLOW_LAT = DIV_CYCLES * DLY_LONG_T + 1;

    psl_word_t hist_q [HIST_DEPTH];
    psl_word_t hist_d [HIST_DEPTH];
    psl_word_t held_q, held_d, out_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic avail_d;

    assign hw_tap = hist_q[HW_T-2];

    always_comb begin
        hist_d = hist_q;
        held_d = held_q;
        cnt_d = cnt_q;
        out_d = out_q;
        avail_d = avail_q;
        if (tick) begin
            hist_d[0] = val;
            for (int i = 1; i < HIST_DEPTH; i++) begin
                hist_d[i] = hist_q[i-1];
            end
            if (cnt_q != '0) begin
                cnt_d = cnt_q - CW'(1);
            end
            // Transfer lands a whole number of ticks after the sample
            if (cnt_q == CW'(1)) begin
                out_d = held_q;
                avail_d = 1'b1;
            end
            if (take) begin
                // Age tap and delay trade off, sum stays constant
                held_d = fast ? hist_q[AGE_LONG_T-1]
                              : hist_q[AGE_SHORT_T-1];
                cnt_d = fast ? CW'(DLY_SHORT_T) : CW'(DLY_LONG_T);
                avail_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hist_q <= '{default: '0};
            held_q <= '0;
            cnt_q <= '0;
            out_q <= '0;
            avail_q <= 1'b0;
        end else begin
            hist_q <= hist_d;
            held_q <= held_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            avail_q <= avail_d;
        end
    end

    // Helper: cycles since the last sample, and its delay setting
    logic [LW-1:0] lat_q;
    logic fast_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lat_q <= '0;
            fast_q <= 1'b0;
        end else if (tick && take) begin
            lat_q <= LW'(1);
            fast_q <= fast;
        end else if (lat_q != '0) begin
            lat_q <= lat_q + LW'(1);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    fast_transfer_a: assert property (
        (take && tick && fast) |-> ##FAST_GAP (out_q == $past(held_q)))
        else $error("short sample delay transfer wrong");
    slow_hold_a: assert property (
        (take && tick && !fast) |=> (!avail_q) [*8])
        else $error("new sample visible before sample delay");
    total_latency_a: assert property (
        $rose(avail_q) |->
            (lat_q == (fast_q ? LW'(FAST_GAP) : LW'(SLOW_LAT))))
        else $error("sample delay length wrong");
    slow_update_c: cover property ($rose(avail_q) && !fast_q);
endmodule

// File: rtl/psl_top.sv
// Operation
// - Strobe falling edge latches axis value at next 10 MHz clock edge.
// - Input-to-register latency constant regardless of sample delay setting.
// - Register update lands whole clock periods after the sample time.
// - One delay bit per register, each affecting only its own register.
// - Bit one: 2951 ns age, 100 ns delay; zero: 251 ns, 2800 ns.
// - Read before the sample delay elapses returns the previous value.
// - Auto-sample: bus read start triggers sampling at next 10 MHz edge.
// - Hardware position output latency constant at about 3051 ns; code gives about 2951 ns, one tick less.
// - Hardware output ignores strobe, refreshed every 10 MHz edge.
// - Extra sampling-path delay shifts age to delay, total unchanged.
`timescale 1ns/1ps
module psl_top import psl_pkg::*; (
    input wire logic clock, // 200 MHz core clock
    input wire logic nrst, // Async reset, active low
    input wire logic sample_n, // Backplane sample strobe pin
    input wire psl_rd_t rd, // Bus read start and register index pins
    input wire logic auto_en, // Auto-sample mode enable
    input wire logic [NREG-1:0] dly_sel, // Sample delay bit per register
    input wire psl_word_t [NREG-1:0] val, // Live axis counters
    output psl_word_t [NREG-1:0] regs, // Readable sampled registers
    output logic [NREG-1:0] avail, // Register holds latest sample
    output psl_word_t [NAXIS-1:0] hw_pos, // Rear hardware position
    output logic tick_q // 10 MHz edge enable pulse
);
    localparam int TICK_GAP = DIV_CYCLES;

    // Sample clock divider
    logic [DW_DIV-1:0] div_q, div_d;
    logic tick_d;
    always_comb begin
        div_d = div_q + DW_DIV'(1);
        tick_d = 1'b0;
        if (div_q == DW_DIV'(DIV_CYCLES - 1)) begin
            div_d = '0;
            tick_d = 1'b1;
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    // Pin synchronisers; stage 1 feeds stage 2 only
    logic smp1_q, smp2_q, smp3_q;
    psl_rd_t rd1_q, rd2_q;
    logic rst3_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            smp1_q <= 1'b1;
            smp2_q <= 1'b1;
            smp3_q <= 1'b1;
            rd1_q <= '0;
            rd2_q <= '0;
            rst3_q <= 1'b0;
        end else begin
            smp1_q <= sample_n;
            smp2_q <= smp1_q;
            smp3_q <= smp2_q;
            rd1_q <= rd;
            rd2_q <= rd1_q;
            rst3_q <= rd2_q.start;
        end
    end

    logic fall, rd_rise;
    assign fall = smp3_q && !smp2_q;
    assign rd_rise = auto_en && rd2_q.start && !rst3_q;

    // Requests wait for the next tick; an edge on the tick cycle is taken
    logic [NREG-1:0] pend_q, pend_d, req, take;
    always_comb begin
        req = {NREG{fall}};
        if (rd_rise) begin
            req[rd2_q.idx] = 1'b1;
        end
        take = tick_q ? (pend_q | req) : '0;
        pend_d = tick_q ? '0 : (pend_q | req);
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // Helper: register index of the latest auto-sample request
    logic [IW-1:0] aidx_q, aidx_d;
    always_comb begin
        aidx_d = aidx_q;
        if (rd_rise) begin
            aidx_d = rd2_q.idx;
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aidx_q <= '0;
        end else begin
            aidx_q <= aidx_d;
        end
    end

    // Helper: cycles that the oldest open request has waited for a tick
    logic [DW_DIV-1:0] wait_q, wait_d;
    always_comb begin
        wait_d = '0;
        if (!tick_q && ((pend_q | req) != '0)) begin
            wait_d = wait_q + DW_DIV'(1);
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wait_q <= '0;
        end else begin
            wait_q <= wait_d;
        end
    end

    psl_word_t [NREG-1:0] tap;
    for (genvar g = 0; g < NREG; g++) begin : g_chan
        psl_chan u_chan (
            .clock(clock),
            .nrst(nrst),
            .tick(tick_q),
            .take(take[g]),
            .fast(dly_sel[g]),
            .val(val[g]),
            .hw_tap(tap[g]),
            .out_q(regs[g]),
            .avail_q(avail[g])
        );
    end

    // Hardware output follows the counters every tick, strobe unused
    psl_word_t [NAXIS-1:0] hw_d;
    always_comb begin
        hw_d = hw_pos;
        if (tick_q) begin
            hw_d = tap[NAXIS-1:0];
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hw_pos <= '0;
        end else begin
            hw_pos <= hw_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    tick_period_a: assert property (
        tick_q |-> ##TICK_GAP tick_q)
        else $error("sample clock period wrong");
    strobe_sample_a: assert property (
        fall |-> ##[0:TICK_GAP] (tick_q && (&take)))
        else $error("strobe not sampled at next tick");
    take_on_tick_a: assert property (
        (|take) |-> tick_q)
        else $error("sample taken off the clock edge");
    auto_sample_a: assert property (
        rd_rise |-> ##[0:TICK_GAP] (tick_q && take[aidx_d]))
        else $error("auto-sample read did not sample");
    hw_refresh_a: assert property (
        tick_q |=> (hw_pos == $past(tap[NAXIS-1:0])))
        else $error("hardware output not refreshed");
    one_sample_a: assert property (
        fall |=> !fall [*2])
        else $error("strobe edge detected twice");
    hw_hold_a: assert property (
        !tick_q |=> $stable(hw_pos))
        else $error("hardware output changed between ticks");

    // Divider and request timing
    wait_bound_a: assert property (
        wait_q < DW_DIV'(DIV_CYCLES))
        else $error("request waited past its tick");
    tick_alone_a: assert property (
        tick_q |=> (!tick_q) [*8])
        else $error("sample clock pulse too close");
    tick_pos_a: assert property (
        tick_q |-> ($past(div_q) == DW_DIV'(DIV_CYCLES - 1)))
        else $error("sample clock pulse off its divider count");
    div_range_a: assert property (
        div_q < DW_DIV'(DIV_CYCLES))
        else $error("sample clock divider out of range");
    pend_keep_a: assert property (
        !tick_q |=> ((pend_q & $past(pend_q)) == $past(pend_q)))
        else $error("pending sample request lost");
    auto_one_a: assert property (
        (rd_rise && !fall && !tick_q && (pend_q == '0)) |=>
            (pend_q == (NREG'(1) << $past(rd2_q.idx))))
        else $error("auto-sample request not for the read register");
    edge_seen_a: assert property (
        $fell(smp2_q) |-> fall)
        else $error("synchronised strobe edge missed");

    // Register status
    avail_drop_a: assert property (
        (|take) |=> ((avail & $past(take)) == '0))
        else $error("sampled register still marked current");
    own_bit_a: assert property (
        ((avail & ~take) != '0) |=>
            ((($past(avail) & ~$past(take)) & ~avail) == '0))
        else $error("sample changed a register it did not address");
    land_on_tick_a: assert property (
        ((avail & ~$past(avail)) != '0) |-> $past(tick_q))
        else $error("register updated off the clock edge");
    regs_steady_a: assert property (
        (avail == '1) |=> $stable(regs))
        else $error("register changed with no sample pending");

    strobe_c: cover property (fall ##[0:TICK_GAP] (|take));
    auto_c: cover property (rd_rise ##[0:TICK_GAP] (|take));
    split_c: cover property ((|take) && (dly_sel != '0) && (~dly_sel != '0));
    auto_fast_c: cover property (rd_rise && dly_sel[rd2_q.idx]);
endmodule

// File: bench/psl_stage_model.sv
`timescale 1ns/1ps
module psl_stage_model import psl_pkg::*; (
    input wire logic clock, // Core clock
    input wire logic nrst, // Reset, active low
    input wire logic tick, // 10 MHz enable
    input wire psl_word_t [NREG-1:0] step, // Motion per tick
    output psl_word_t [NREG-1:0] val // Axis counters
);
    psl_word_t [NREG-1:0] val_d;
    // Stage moves once per tick, so each tick sees one fresh value
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            val_d[i] = tick ? val[i] + step[i] : val[i];
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            val <= '0;
        end else begin
            val <= val_d;
        end
    end
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench import psl_pkg::*;;
    logic clock = 0, nrst = 0, sample_n = 1, auto_en = 0, tick_q, tick_p = 0;
    psl_rd_t rd = '0;
    logic [NREG-1:0] dly_sel = '1, avail, avl_p = '0, pend = '0;
    psl_word_t [NREG-1:0] val, regs, step = '0;
    psl_word_t [NAXIS-1:0] hw_pos;
    psl_word_t [NREG-1:0] hist [0:2047];
    psl_word_t held [NREG];
    int nt = 0, cyc = 0, lands = 0, err_total = 0, compares = 0, tick_c = 0;
    int fall_c [NREG], take_t [NREG], dd [NREG];

    always #2.5 clock = ~clock;

    psl_top psl_top_inst (.clock(clock), .nrst(nrst), .sample_n(sample_n),
        .rd(rd), .auto_en(auto_en), .dly_sel(dly_sel), .val(val),
        .regs(regs), .avail(avail), .hw_pos(hw_pos), .tick_q(tick_q));
    psl_stage_model psl_stage_model_inst (.clock(clock), .nrst(nrst),
        .tick(tick_q), .step(step), .val(val));

    task automatic chk(input string nm, input psl_word_t e, input psl_word_t g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Value the register should hold: counter as it stood age ticks earlier
    function automatic psl_word_t exp_val(input int i, input int t, input int d);
        return hist[t - (d == 1 ? 29 : 2)][i];
    endfunction

    always @(negedge clock) begin
        cyc++;
        if (tick_p && nt > 30) begin
            for (int k = 0; k < NAXIS; k++) begin
                chk("hw_pos", hist[nt - 30][k], hw_pos[k]);
            end
        end
        tick_p = (tick_q === 1'b1);
        if (tick_p) begin
            if (nt > 0) begin
                chk("tick gap", DIV_CYCLES, cyc - tick_c);
            end
            tick_c = cyc;
            hist[nt] = val;
            nt++;
        end
        for (int i = 0; i < NREG; i++) begin
            if (avl_p[i] === 1'b1 && avail[i] === 1'b0) begin
                pend[i] = 1;
                fall_c[i] = cyc;
                take_t[i] = nt - 1;
                dd[i] = dly_sel[i] ? 1 : 28;
                held[i] = regs[i];
            end else if (pend[i] && avail[i] === 1'b1) begin
                pend[i] = 0;
                lands++;
                chk("delay", 20 * dd[i], cyc - fall_c[i]);
                chk("regs", exp_val(i, take_t[i], dd[i]), regs[i]);
            end else if (pend[i]) begin
                chk("held", held[i], regs[i]);
            end
        end
        avl_p = avail;
    end

    task automatic wait_done(input int exp);
        int n;
        n = 0;
        while (!(lands == exp && avail === '1) && n < 1000) begin
            @(posedge clock);
            n++;
        end
        if (n == 1000) begin
            err_total++;
            $display("mismatch lands expected %0d seen %0d", exp, lands);
            stop_test();
        end
    endtask

    task automatic strobe(input logic [NREG-1:0] sel, input int exp);
        @(posedge clock);
        dly_sel <= sel;
        for (int i = 0; i < NREG; i++) begin
            step[i] <= $urandom;
        end
        lands = 0;
        repeat ($urandom_range(19, 1)) @(posedge clock);
        sample_n <= 0;
        // Held low across two ticks: still only one sample
        repeat (45) @(posedge clock);
        sample_n <= 1;
        wait_done(exp);
        $display("test strobe sel %h done", sel);
    endtask

    task automatic autos(input int idx, input logic en);
        @(posedge clock);
        auto_en <= en;
        dly_sel <= '1;
        rd.idx <= idx[IW-1:0];
        lands = 0;
        repeat ($urandom_range(19, 1)) @(posedge clock);
        rd.start <= 1;
        repeat (50) @(posedge clock);
        chk("auto ready", psl_word_t'(en), lands);
        rd.start <= 0;
        wait_done(int'(en));
        $display("test auto reg %0d en %0d done", idx, en);
    endtask

    initial begin
        void'($urandom(32'h0162));
        repeat (6) @(posedge clock);
        nrst <= 1;
        strobe('1, 0);
        for (int n = 0; n < 1000 && nt < 32; n++) begin
            @(posedge clock);
        end
        if (nt < 32) begin
            err_total++;
            $display("mismatch ticks expected 32 seen %0d", nt);
            stop_test();
        end
        strobe('0, NREG);
        strobe('1, NREG);
        for (int t = 0; t < 6; t++) begin
            strobe(NREG'($urandom), NREG);
        end
        for (int t = 0; t < NREG; t++) begin
            autos(t, 1'b1);
        end
        autos(3, 1'b0);
        stop_test();
    end
endmodule
